// ### design/hpp_pkg.sv
/*
  package for the host processor port: mode encoding, state encoding and
  address field positions shared by the device end and the host end.
  assumes nothing beyond a single clock taken from the host bus clock.
*/
package hpp_pkg;

  // processor bus modes: first mode and second mode
  typedef enum logic {
    HPP_MODE_FIRST  = 1'b0,  // acknowledge high, direction low = write
    HPP_MODE_SECOND = 1'b1   // ready low, direction high = write
  } hpp_mode_t;

  // transfer state, gray coded along idle -> busy -> done
  typedef enum logic [1:0] {
    HPP_IDLE = 2'b00,
    HPP_BUSY = 2'b01,
    HPP_DONE = 2'b11
  } hpp_state_t;

  localparam int unsigned HPP_ADDR_W    = 5;     // device address width
  localparam int unsigned HPP_DATA_W    = 8;     // user data width
  localparam int unsigned HPP_BYTE_LSB  = 0;     // byte lane bits sit at 1:0
  localparam int unsigned HPP_UPPER_LSB = 2;     // upper bits 4:2
  localparam logic        HPP_IRQ_RST   = 1'b1;  // irq idle level (high)
  localparam logic        HPP_ACK_RST   = 1'b0;  // first mode ack idle level
  localparam logic        HPP_RDY_RST   = 1'b1;  // second mode ready idle level
  localparam logic [1:0]  HPP_WAIT_CYC  = 2'h1;  // busy cycles before answer

endpackage

// ### design/hpp_if.sv
/*
  interface joining the host end and the device end of the host processor
  port. assumes both ends run on the host bus clock, driven by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
interface hpp_if;
  import hpp_pkg::*;

  logic                  host_bus_clock;       // clock driven by the bench
  logic                  transfer_strobe_in;   // start or address/data strobe, low
  logic                  direction_in;         // direction, polarity by mode
  logic [HPP_ADDR_W-1:0] addr;                 // device address, bit 4 msb
  logic [1:0]            byte_lane_select;     // low address bits, second mode
  logic [HPP_DATA_W-1:0] wdata;                // host write data
  logic [HPP_DATA_W-1:0] rdata;                // device read data
  logic                  transfer_done_out;    // ack high / ready low pin
  logic                  burst_inhibit_out;    // burst inhibit, high
  logic                  host_irq_n;           // interrupt request, low

  modport device (
    input  host_bus_clock, transfer_strobe_in, direction_in, addr, byte_lane_select, wdata,
    output rdata, transfer_done_out, burst_inhibit_out, host_irq_n
  );
  modport host (
    input  host_bus_clock, rdata, transfer_done_out, burst_inhibit_out, host_irq_n,
    output transfer_strobe_in, direction_in, addr, byte_lane_select, wdata
  );
endinterface
`default_nettype wire

// ### design/hpp_device.sv
/*
  device end of the host processor port: samples strobe, direction and
  address on the host bus clock, answers with ack (first mode) or ready
  (second mode), drives burst inhibit and the low interrupt request.
  one transfer is handled at a time: strobe taken, one busy cycle, answer
  for one cycle, which is also the recovery cycle before the next strobe is taken.
  while the port is not in use its pins act as plain user pins.
  assumes the host keeps to direction polarity and strobe rules of its mode.
  assumes every input comes from logic on the host bus clock.
*/
`timescale 1ns/10ps
`default_nettype none
module hpp_device
  import hpp_pkg::*;
(
  hpp_if.device                 bus,            // pin side
  input  wire logic             i_rst_b,        // sync reset, low
  input  wire hpp_mode_t        i_mode,         // processor bus mode
  input  wire logic             i_port_enable,  // port in use
  input  wire logic             i_irq,          // user interrupt request level
  input  wire logic [HPP_DATA_W-1:0] i_rdata,   // user read data
  input  wire logic [3:0]       i_user_out,     // user pin drive when unused
  output logic                  o_wr_stb,       // one-cycle write pulse
  output logic                  o_rd_stb,       // one-cycle read pulse
  output logic [HPP_ADDR_W-1:0] o_addr,         // decoded device address
  output logic [HPP_DATA_W-1:0] o_wdata,        // captured write data
  output logic [3:0]            o_user_in,      // user pin sample when unused
  output logic                  o_busy          // transfer in progress
);

  hpp_state_t            state;       // transfer state
  logic [1:0]            wait_cnt;    // busy counter
  logic                  done_pin;    // registered ack/ready pin
  logic                  bi_pin;      // registered burst inhibit
  logic                  irq_pin;     // registered irq
  logic [HPP_ADDR_W-1:0] next_addr;   // address mapped per mode
  logic                  is_write;    // direction decoded per mode
  logic                  take;        // strobe accepted this edge
  logic                  answer;      // last busy cycle, answer due

  // direction polarity differs by mode, the host keeps it; the device
  // only decodes it, a host using the wrong polarity swaps read and write
  always_comb begin
    if (i_mode == HPP_MODE_FIRST) begin
      is_write = ~bus.direction_in;
    end else begin
      is_write = bus.direction_in;
    end
  end

  // address mapping per mode; in second mode only the byte lanes count
  // and the upper pins are free to carry anything
  always_comb begin
    if (i_mode == HPP_MODE_FIRST) begin
      next_addr = bus.addr;  // pins carry the host bits unchanged, 4 msb
    end else begin
      next_addr = {3'h0, bus.byte_lane_select};  // upper bits dropped
    end
  end

  // a strobe is taken only while idle and the port is in use, so a strobe
  // that arrives during a transfer is dropped rather than queued
  assign take = i_port_enable && !bus.transfer_strobe_in && (state == HPP_IDLE);

  // the answer is launched on the last busy edge
  assign answer = (state == HPP_BUSY) && (wait_cnt == 2'h1);

  // transfer state: idle, busy while the user side works, done for one cycle
  always_ff @(posedge bus.host_bus_clock) begin
    if (!i_rst_b) begin
      state <= HPP_IDLE;  // no transfer after reset
    end else begin
      case (state)
        HPP_IDLE: begin
          if (take) begin
            state <= HPP_BUSY;  // strobe low starts a transfer
          end
        end
        HPP_BUSY: begin
          if (answer) begin
            state <= HPP_DONE;  // answer goes out now
          end
        end
        HPP_DONE: begin
          state <= HPP_IDLE;  // one recovery cycle before the next strobe
        end
        default: begin
          state <= HPP_IDLE;  // unused code falls back to idle
        end
      endcase
    end
  end

  // busy counter, loaded at the strobe and run down while busy
  always_ff @(posedge bus.host_bus_clock) begin
    if (!i_rst_b) begin
      wait_cnt <= 2'h0;
    end else if (take) begin
      wait_cnt <= HPP_WAIT_CYC;  // fixed wait before the answer
    end else if ((state == HPP_BUSY) && !answer) begin
      wait_cnt <= wait_cnt - 2'h1;  // count down the extra busy cycles
    end
  end

  // one-cycle write and read pulses toward the user logic
  always_ff @(posedge bus.host_bus_clock) begin
    if (!i_rst_b) begin
      o_wr_stb <= 1'b0;
      o_rd_stb <= 1'b0;
    end else begin
      o_wr_stb <= take && is_write;
      o_rd_stb <= take && !is_write;
    end
  end

  // address and write data held from the taken strobe until the next one
  always_ff @(posedge bus.host_bus_clock) begin
    if (!i_rst_b) begin
      o_addr  <= '0;
      o_wdata <= '0;
    end else if (take) begin
      o_addr  <= next_addr;
      o_wdata <= bus.wdata;
    end
  end

  // acknowledge or ready pin, active for the one cycle that the state
  // machine spends in done; in reset the pin rests at the idle level of
  // the selected mode, so a second-mode host never sees a false ready
  // (ready is low-active, an ack reset value of zero would read as ready)
  always_ff @(posedge bus.host_bus_clock) begin
    if (!i_rst_b) begin
      if (i_mode == HPP_MODE_FIRST) begin
        done_pin <= HPP_ACK_RST;  // ack idle low
      end else begin
        done_pin <= HPP_RDY_RST;  // ready idle high
      end
    end else if (!i_port_enable) begin
      done_pin <= i_user_out[0];  // plain user pin
    end else if (i_mode == HPP_MODE_FIRST) begin
      done_pin <= answer;  // ack high
    end else begin
      done_pin <= ~answer;  // ready low
    end
  end

  // burst inhibit, high in first mode: this port never bursts, so the
  // host is told to split every access; second mode has no such pin
  // and the line rests low
  always_ff @(posedge bus.host_bus_clock) begin
    if (!i_rst_b) begin
      bi_pin <= 1'b0;
    end else if (!i_port_enable) begin
      bi_pin <= i_user_out[1];
    end else begin
      bi_pin <= (i_mode == HPP_MODE_FIRST);
    end
  end

  // interrupt request, active low; the user level is registered once so
  // the pin cannot glitch between host clock edges and lags the level
  // by exactly one cycle
  always_ff @(posedge bus.host_bus_clock) begin
    if (!i_rst_b) begin
      irq_pin <= HPP_IRQ_RST;
    end else if (!i_port_enable) begin
      irq_pin <= i_user_out[2];
    end else begin
      irq_pin <= ~i_irq;
    end
  end

  // read data and user input sampling; read data is the user word one
  // edge late, so the user side must hold it through the transfer.
  // user pins are only sampled while the port is not in use
  always_ff @(posedge bus.host_bus_clock) begin
    if (!i_rst_b) begin
      bus.rdata <= '0;
      o_user_in <= 4'h0;
      o_busy    <= 1'b0;
    end else begin
      bus.rdata <= i_rdata;
      o_user_in <= i_port_enable ? 4'h0 : {bus.direction_in, bus.transfer_strobe_in,
                                           bus.byte_lane_select};
      o_busy    <= (state != HPP_IDLE);
    end
  end

  // every pin comes straight from its own flip-flop
  assign bus.transfer_done_out = done_pin;
  assign bus.burst_inhibit_out = bi_pin;
  assign bus.host_irq_n        = irq_pin;

endmodule
`default_nettype wire

// ### design/hpp_host.sv
/*
  host end of the host processor port: issues one transfer per request,
  drives direction with the mode's polarity and waits for ack or ready.
  assumes the bench drives the host bus clock into the interface.
*/
`timescale 1ns/10ps
`default_nettype none
module hpp_host
  import hpp_pkg::*;
(
  hpp_if.host                   bus,       // pin side
  input  wire logic             i_rst_b,   // sync reset, low
  input  wire hpp_mode_t        i_mode,    // processor bus mode
  input  wire logic             i_req,     // request pulse
  input  wire logic             i_write,   // 1 write, 0 read
  input  wire logic [HPP_ADDR_W-1:0] i_addr,  // device address
  input  wire logic [HPP_DATA_W-1:0] i_wdata, // write data
  output logic                  o_done,    // one-cycle completion pulse
  output logic [HPP_DATA_W-1:0] o_rdata,   // read data
  output logic                  o_irq,     // synchronised interrupt, high
  output logic                  o_burst_inhibit  // burst inhibit seen
);

  logic                  active;   // transfer outstanding
  logic                  strb;     // strobe pin register
  logic                  dir;      // direction pin register
  logic [HPP_ADDR_W-1:0] addr;     // address pins
  logic [1:0]            lanes;    // byte lane pins
  logic [HPP_DATA_W-1:0] wdata;    // data pins
  logic                  done_seen; // answer decoded per mode

  // ack high in first mode, ready low in second
  always_comb begin
    if (i_mode == HPP_MODE_FIRST) begin
      done_seen = bus.transfer_done_out;
    end else begin
      done_seen = ~bus.transfer_done_out;
    end
  end

  // request driver, one strobe cycle per transfer
  always_ff @(posedge bus.host_bus_clock) begin
    if (!i_rst_b) begin
      active <= 1'b0;
      strb   <= 1'b1;
      dir    <= 1'b1;
      addr   <= '0;
      lanes  <= 2'h0;
      wdata  <= '0;
      o_done <= 1'b0;
      o_rdata <= '0;
    end else begin
      strb   <= 1'b1;
      o_done <= 1'b0;
      if (!active && i_req) begin
        active <= 1'b1;
        strb   <= 1'b0;
        dir    <= (i_mode == HPP_MODE_FIRST) ? ~i_write : i_write;
        addr   <= i_addr;
        lanes  <= i_addr[1:0];
        wdata  <= i_wdata;
      end else if (active && done_seen) begin
        active  <= 1'b0;
        o_done  <= 1'b1;
        o_rdata <= bus.rdata;
      end
    end
  end

  // status pins from device logic on the same clock
  always_ff @(posedge bus.host_bus_clock) begin
    if (!i_rst_b) begin
      o_irq           <= 1'b0;
      o_burst_inhibit <= 1'b0;
    end else begin
      o_irq           <= ~bus.host_irq_n;
      o_burst_inhibit <= bus.burst_inhibit_out;
    end
  end

  assign bus.transfer_strobe_in = strb;
  assign bus.direction_in       = dir;
  assign bus.addr               = addr;
  assign bus.byte_lane_select   = lanes;
  assign bus.wdata              = wdata;

endmodule
`default_nettype wire

// ### test/hpp_props.sv
/*
  checker for the host processor port pins between host end and device end.
  assumes it sits beside the interface and sees the device user inputs.
*/
`timescale 1ns/10ps
`default_nettype none
module hpp_props
  import hpp_pkg::*;
(
  input wire logic       host_bus_clock,     // port clock
  input wire logic       i_rst_b,            // sync reset, low
  input wire hpp_mode_t  i_mode,             // bus mode
  input wire logic       i_port_enable,      // port in use
  input wire logic       i_irq,              // user irq level
  input wire logic       transfer_strobe_in, // start strobe, low
  input wire logic       transfer_done_out,  // ack or ready pin
  input wire logic       burst_inhibit_out,  // burst inhibit pin
  input wire logic       host_irq_n          // irq pin, low
);
  default clocking cb @(posedge host_bus_clock); endclocking
  default disable iff (!i_rst_b);
  // irq pin follows the user level one cycle later
  chk_irq_level: assert property (i_port_enable && i_irq ##1 i_port_enable |-> !host_irq_n)
    else $error("irq pin not low");
  chk_irq_idle: assert property (i_port_enable && !i_irq ##1 i_port_enable |-> host_irq_n)
    else $error("irq pin not high");
  // burst inhibit only in first mode
  chk_bi_first: assert property (
    i_port_enable && i_mode == HPP_MODE_FIRST ##1 i_port_enable |-> burst_inhibit_out)
    else $error("burst inhibit missing");
  chk_bi_second: assert property (
    i_port_enable && i_mode == HPP_MODE_SECOND ##1 i_port_enable |-> !burst_inhibit_out)
    else $error("burst inhibit in second mode");
  // a taken strobe is answered two edges later with the mode's level, for one cycle
  chk_ack_answer: assert property (
    !transfer_strobe_in && i_port_enable |-> ##2 (transfer_done_out == (i_mode == HPP_MODE_FIRST))
    ##1 $changed(transfer_done_out))
    else $error("no answer to strobe");
  // the answer never comes without a strobe before it
  chk_ack_cause: assert property (
    i_port_enable && $past(i_port_enable) && i_mode == HPP_MODE_FIRST && $past(i_mode) == HPP_MODE_FIRST
    && transfer_done_out |-> $past(transfer_strobe_in, 2) == 1'b0)
    else $error("ack without strobe");
  chk_rdy_cause: assert property (
    i_port_enable && $past(i_port_enable) && i_mode == HPP_MODE_SECOND && $past(i_mode) == HPP_MODE_SECOND
    && !transfer_done_out |-> $past(transfer_strobe_in, 2) == 1'b0)
    else $error("ready without strobe");
  // host strobe lasts a single cycle
  chk_strobe_pulse: assert property (!transfer_strobe_in |=> transfer_strobe_in)
    else $error("strobe held too long");
endmodule
`default_nettype wire

// ### test/tb_hpp.sv
/*
  testbench joining host end and device end through the interface.
  assumes the port clock is the bench clock and the checker sits beside it.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_hpp;
  import hpp_pkg::*;
  logic i_clk, i_rst_b, port_en, irq, req, write, done, h_irq, h_bi;
  logic wr_stb, rd_stb, busy, got_w, seen_dir;
  hpp_mode_t mode;                       // bus mode under test
  logic [4:0] haddr, d_addr, got_addr;   // addresses
  logic [7:0] hwdata, dev_rdata, d_wdata, h_rdata, got_data;
  logic [3:0] user_out, user_in;         // user pin side
  int err_total, check_count, cycles;
  hpp_if bus();
  assign bus.host_bus_clock = i_clk;     // port clock from bench
  always #50 i_clk = ~i_clk;
  hpp_device u_hpp_device (.bus(bus), .i_rst_b(i_rst_b), .i_mode(mode), .i_port_enable(port_en), .i_irq(irq),
    .i_rdata(dev_rdata), .i_user_out(user_out), .o_wr_stb(wr_stb), .o_rd_stb(rd_stb), .o_addr(d_addr),
    .o_wdata(d_wdata), .o_user_in(user_in), .o_busy(busy));
  hpp_host u_hpp_host (.bus(bus), .i_rst_b(i_rst_b), .i_mode(mode), .i_req(req), .i_write(write), .i_addr(haddr),
    .i_wdata(hwdata), .o_done(done), .o_rdata(h_rdata), .o_irq(h_irq), .o_burst_inhibit(h_bi));
  hpp_props u_hpp_props (.host_bus_clock(bus.host_bus_clock), .i_rst_b(i_rst_b), .i_mode(mode),
    .i_port_enable(port_en), .i_irq(irq), .transfer_strobe_in(bus.transfer_strobe_in),
    .transfer_done_out(bus.transfer_done_out), .burst_inhibit_out(bus.burst_inhibit_out),
    .host_irq_n(bus.host_irq_n));
  // capture direction at the strobe and what the device decoded
  always @(posedge i_clk) begin
    if (!bus.transfer_strobe_in) seen_dir <= bus.direction_in;
    if (wr_stb || rd_stb) begin
      got_w <= wr_stb;
      got_addr <= d_addr;
      got_data <= d_wdata;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one host transfer, bounded wait on completion
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge i_clk); #1;
    req = 1; write = w; haddr = a; hwdata = d;
    @(posedge i_clk); #1;
    req = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge i_clk); #1;
      n++;
    end
    if (n == 20) check(8'h00, 8'h01);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    i_clk = 0; i_rst_b = 0; mode = HPP_MODE_FIRST; port_en = 1; irq = 0; dev_rdata = 8'h5A;
    user_out = 4'h2; req = 0; write = 0; haddr = 5'h00; hwdata = 8'h00;
    repeat (3) @(posedge i_clk); #1;
    check({5'h0, bus.host_irq_n, bus.burst_inhibit_out, bus.transfer_done_out}, 8'h04);
    check({7'h0, busy}, 8'h00);
    i_rst_b = 1;
    for (int m = 0; m < 2; m++) begin
      mode = hpp_mode_t'(m[0]);
      repeat (2) @(posedge i_clk); #1;
      check({7'h0, bus.burst_inhibit_out}, {7'h0, m == 0});
      xfer(1'b1, 5'h13, 8'hA5);
      check({7'h0, busy}, 8'h01);
      check({7'h0, got_w}, 8'h01);
      check({7'h0, seen_dir}, {7'h0, m[0]});
      check({3'h0, got_addr}, m ? 8'h03 : 8'h13);
      check(got_data, 8'hA5);
      xfer(1'b0, 5'h0E, 8'h00);
      check({7'h0, got_w}, 8'h00);
      check({7'h0, seen_dir}, {7'h0, ~m[0]});
      check({3'h0, got_addr}, m ? 8'h02 : 8'h0E);
      check(h_rdata, 8'h5A);
      check({7'h0, h_bi}, {7'h0, m == 0});
      $display("test transfers mode %0d over", m);
    end
    irq = 1;
    repeat (3) @(posedge i_clk); #1;
    check({6'h0, bus.host_irq_n, h_irq}, 8'h01);
    irq = 0;
    repeat (3) @(posedge i_clk); #1;
    check({7'h0, bus.host_irq_n}, 8'h01);
    $display("test irq over");
    i_rst_b = 0;
    repeat (2) @(posedge i_clk); #1;
    check({5'h0, bus.host_irq_n, bus.burst_inhibit_out, bus.transfer_done_out}, 8'h05);
    check({7'h0, busy}, 8'h00);
    i_rst_b = 1;
    xfer(1'b1, 5'h1D, 8'h3C);
    check({3'h0, got_addr}, 8'h01);
    check(got_data, 8'h3C);
    $display("test reset in second mode over");
    port_en = 0;
    repeat (3) @(posedge i_clk); #1;
    check({5'h0, bus.host_irq_n, bus.burst_inhibit_out, bus.transfer_done_out}, 8'h02);
    check({4'h0, user_in}, 8'h0D);
    $display("test user pins over");
    tally_and_finish();
  end
endmodule
`default_nettype wire
